//--- design/infrared_carrier_transmitter.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RL1 - timer clock is peripheral clock over 2^exp
// RL2 - carrier low for rise count, then high
// RL3 - carrier low again after period count
// RL4 - bit lasts 1 to 256 carrier periods
// RL5 - carrier gated by sequence drives output pin
// RL6 - optional inversion of the modulated output
// RL7 - sequence fetched as words from start pointer
// RL8 - length 1 to 4096, else no start
// RL9 - busy status while transmission runs
// RL10 - single end-of-transmission interrupt when enabled
// RL11 - invalid enable settings rejected and reported
// RL12 - disable leaves infra-red mode, releases pin
// RL13 - controller enables before start, poll, disable
// RL14 - controller avoids ordinary timer controls meanwhile
// RL15 - bit 0 first, one passes carrier, zero idles
module infrared_carrier_transmitter
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_read_data,
	output logic mem_read,
	output logic [31:0] mem_address,
	input wire logic [31:0] mem_data,
	input wire logic mem_ready,
	output logic tx_pin,
	output logic tx_pin_oe,
	output logic end_irq
);
	// ************************************************************
	// register state
	// ************************************************************
	ir_tx_pkg::carrier_cfg_s cfg; // carrier shape
	logic [8:0] bit_length_in_carriers; // carriers per bit
	logic [31:0] sequence_start_pointer; // first word address
	logic output_polarity_flip; // invert pin
	logic end_irq_enable; // interrupt gate
	logic enabled; // infra-red mode on
	logic done; // sticky end of transmission
	logic enable_rejected; // sticky bad enable
	logic start_rejected; // sticky bad start
	ir_tx_pkg::tx_state_e state; // sequencer
	logic busy; // transmission in progress

	// decoded strobes
	logic wr_ctrl, wr_carrier, wr_bitlen, wr_pointer, wr_start, wr_status;
	assign wr_ctrl = reg_write && reg_address == ir_tx_pkg::CONTROL_OFFSET;
	assign wr_carrier = reg_write && reg_address == ir_tx_pkg::CARRIER_OFFSET;
	assign wr_bitlen = reg_write && reg_address == ir_tx_pkg::BIT_LENGTH_OFFSET;
	assign wr_pointer = reg_write && reg_address == ir_tx_pkg::POINTER_OFFSET;
	assign wr_start = reg_write && reg_address == ir_tx_pkg::START_OFFSET;
	assign wr_status = reg_write && reg_address == ir_tx_pkg::STATUS_OFFSET;

	// fields of a control write
	logic [4:0] new_exp;
	logic enable_valid; // settings acceptable
	assign new_exp = reg_write_data[ir_tx_pkg::CTRL_EXP_LSB +: 5];
	assign enable_valid = (new_exp <= ir_tx_pkg::EXPONENT_MAX)
		&& (cfg.carrier_period_count != 16'h0000)
		&& (cfg.carrier_rise_count < cfg.carrier_period_count)
		&& (bit_length_in_carriers != 9'h000)
		&& (bit_length_in_carriers <= ir_tx_pkg::BIT_LENGTH_MAX); // RL11

	// fields of a start write
	logic [12:0] new_count;
	logic start_valid; // transmission may begin
	logic end_of_sequence; // last bit finished
	assign new_count = reg_write_data[12:0];
	assign start_valid = enabled && !busy
		&& (new_count != 13'h0000)
		&& (new_count <= ir_tx_pkg::SEQUENCE_MAX)
		&& (reg_write_data[31:13] == 19'h0_0000)
		&& (sequence_start_pointer[1:0] == 2'b00); // RL8

	// ************************************************************
	// configuration registers
	// ************************************************************
	// rise, period and bit length locked while enabled
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg.carrier_rise_count <= ir_tx_pkg::CARRIER_RESET;
			cfg.carrier_period_count <= ir_tx_pkg::CARRIER_RESET;
			bit_length_in_carriers <= ir_tx_pkg::BIT_LENGTH_RESET;
			sequence_start_pointer <= ir_tx_pkg::POINTER_RESET;
			cfg.clock_divide_exponent <= 5'h00;
		end
		else
		begin
			if (wr_carrier && !enabled)
			begin
				cfg.carrier_rise_count <= reg_write_data[15:0];
				cfg.carrier_period_count <=
					reg_write_data[ir_tx_pkg::CARRIER_PERIOD_LSB +: 16];
			end
			if (wr_bitlen && !enabled)
				bit_length_in_carriers <= reg_write_data[8:0]; // RL4
			if (wr_pointer && !busy)
				sequence_start_pointer <= reg_write_data; // RL7
			// exponent taken only with an accepted enable
			if (wr_ctrl && reg_write_data[ir_tx_pkg::CTRL_ENABLE_BIT]
				&& enable_valid)
				cfg.clock_divide_exponent <= new_exp; // RL1
		end
	end

	// enable request validated, disable always honoured
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			enabled <= 1'b0;
			output_polarity_flip <= 1'b0;
			end_irq_enable <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			if (reg_write_data[ir_tx_pkg::CTRL_ENABLE_BIT] && enable_valid)
			begin
				enabled <= 1'b1;
				output_polarity_flip <=
					reg_write_data[ir_tx_pkg::CTRL_FLIP_BIT];
				end_irq_enable <= reg_write_data[ir_tx_pkg::CTRL_IRQ_BIT];
			end
			else
				enabled <= 1'b0; // RL12
		end
	end

	// ************************************************************
	// sticky status flags: set wins over clear
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			done <= 1'b0;
			enable_rejected <= 1'b0;
			start_rejected <= 1'b0;
		end
		else
		begin
			if (end_of_sequence)
				done <= 1'b1; // RL10
			else if (wr_status && reg_write_data[ir_tx_pkg::STATUS_DONE_BIT])
				done <= 1'b0;
			if (wr_ctrl && reg_write_data[ir_tx_pkg::CTRL_ENABLE_BIT]
				&& !enable_valid)
				enable_rejected <= 1'b1; // RL11
			else if (wr_status && reg_write_data[ir_tx_pkg::STATUS_ENREJ_BIT])
				enable_rejected <= 1'b0;
			if (wr_start && !start_valid)
				start_rejected <= 1'b1; // RL8
			else if (wr_status && reg_write_data[ir_tx_pkg::STATUS_STREJ_BIT])
				start_rejected <= 1'b0;
		end
	end

	assign end_irq = done && end_irq_enable && enabled; // RL10

	// ************************************************************
	// read port
	// ************************************************************
	logic [31:0] next_read_data;

	// mux, unmapped reads zero
	always_comb
	begin
		next_read_data = 32'h0000_0000;
		unique case (reg_address)
			ir_tx_pkg::CONTROL_OFFSET:
			begin
				next_read_data[ir_tx_pkg::CTRL_ENABLE_BIT] = enabled;
				next_read_data[ir_tx_pkg::CTRL_FLIP_BIT] = output_polarity_flip;
				next_read_data[ir_tx_pkg::CTRL_IRQ_BIT] = end_irq_enable;
				next_read_data[ir_tx_pkg::CTRL_EXP_LSB +: 5] =
					cfg.clock_divide_exponent;
			end
			ir_tx_pkg::CARRIER_OFFSET:
				next_read_data = {cfg.carrier_period_count,
					cfg.carrier_rise_count};
			ir_tx_pkg::BIT_LENGTH_OFFSET:
				next_read_data[8:0] = bit_length_in_carriers;
			ir_tx_pkg::POINTER_OFFSET:
				next_read_data = sequence_start_pointer;
			ir_tx_pkg::STATUS_OFFSET:
			begin
				next_read_data[ir_tx_pkg::STATUS_BUSY_BIT] = busy; // RL9
				next_read_data[ir_tx_pkg::STATUS_ENABLED_BIT] = enabled;
				next_read_data[ir_tx_pkg::STATUS_DONE_BIT] = done;
				next_read_data[ir_tx_pkg::STATUS_ENREJ_BIT] = enable_rejected;
				next_read_data[ir_tx_pkg::STATUS_STREJ_BIT] = start_rejected;
			end
			default:
				next_read_data = 32'h0000_0000;
		endcase
	end

	// data only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			reg_read_data <= 32'h0000_0000;
		else if (reg_read)
			reg_read_data <= next_read_data;
		else
			reg_read_data <= 32'h0000_0000;
	end

	// ************************************************************
	// carrier
	// ************************************************************
	logic carrier, period_end;

	carrier_generator carrier_generator_i
	(
		.clock(clock),
		.reset_n(reset_n),
		.run(state == ir_tx_pkg::ST_SEND),
		.cfg(cfg),
		.carrier(carrier),
		.period_end(period_end)
	);

	// ************************************************************
	// sequencer
	// ************************************************************
	logic [31:0] word_now; // word being sent
	logic [31:0] word_next; // prefetched word
	logic next_full; // prefetch landed
	logic [4:0] bit_index; // position in word
	logic [12:0] bits_left; // bits incl. current
	logic [8:0] carrier_index; // carriers into bit
	logic bit_end; // current bit finished
	logic word_end; // last bit of the word
	logic fetch_wait; // read outstanding

	assign busy = (state != ir_tx_pkg::ST_IDLE); // RL9
	assign bit_end = (state == ir_tx_pkg::ST_SEND) && period_end
		&& (carrier_index == bit_length_in_carriers - 9'h001); // RL4
	assign end_of_sequence = bit_end && (bits_left == 13'h0001);
	assign word_end = bit_end && (bit_index == 5'h1F) && !end_of_sequence;

	// carriers within the current bit
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			carrier_index <= 9'h000;
		else if (state != ir_tx_pkg::ST_SEND || bit_end)
			carrier_index <= 9'h000;
		else if (period_end)
			carrier_index <= carrier_index + 9'h001; // RL4
	end

	// state, bit walk and word hand-over
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ir_tx_pkg::ST_IDLE;
			word_now <= 32'h0000_0000;
			bit_index <= 5'h00;
			bits_left <= 13'h0000;
		end
		else if (!enabled)
			state <= ir_tx_pkg::ST_IDLE; // RL12
		else
		begin
			unique case (state)
				ir_tx_pkg::ST_IDLE:
					if (wr_start && start_valid)
					begin
						bits_left <= new_count;
						state <= ir_tx_pkg::ST_LOAD;
					end
				ir_tx_pkg::ST_LOAD, ir_tx_pkg::ST_STALL:
					if (mem_ready)
					begin
						word_now <= mem_data;
						bit_index <= 5'h00; // RL15
						state <= ir_tx_pkg::ST_SEND;
					end
				ir_tx_pkg::ST_SEND:
					if (end_of_sequence)
						state <= ir_tx_pkg::ST_IDLE;
					else if (bit_end)
					begin
						bits_left <= bits_left - 13'h0001;
						bit_index <= bit_index + 5'h01; // RL15
						if (word_end && next_full)
							word_now <= word_next;
						else if (word_end && mem_ready && fetch_wait)
							word_now <= mem_data; // lands just in time
						else if (word_end)
							state <= ir_tx_pkg::ST_STALL;
					end
			endcase
		end
	end

	// ************************************************************
	// word fetch with one word of lookahead
	// ************************************************************
	logic want_more; // a loaded word leaves bits for another

	// at a word end the finishing bit still counts in bits_left
	assign want_more =
		(bits_left - {12'h000, word_end}) > ir_tx_pkg::WORD_BITS;

	// read strobe, address walk and prefetch slot
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_read <= 1'b0;
			mem_address <= 32'h0000_0000;
			fetch_wait <= 1'b0;
			word_next <= 32'h0000_0000;
			next_full <= 1'b0;
		end
		else
		begin
			mem_read <= 1'b0;
			if (!enabled)
			begin
				fetch_wait <= 1'b0;
				next_full <= 1'b0;
			end
			else if (state == ir_tx_pkg::ST_IDLE && wr_start && start_valid)
			begin
				mem_read <= 1'b1;
				mem_address <= sequence_start_pointer; // RL7
				fetch_wait <= 1'b1;
				next_full <= 1'b0;
			end
			else if (mem_ready && fetch_wait)
			begin
				fetch_wait <= 1'b0;
				if (state == ir_tx_pkg::ST_SEND && !word_end)
				begin
					word_next <= mem_data;
					next_full <= 1'b1;
				end
				else if (want_more)
				begin
					mem_read <= 1'b1;
					mem_address <= mem_address + ir_tx_pkg::WORD_STEP;
					fetch_wait <= 1'b1;
				end
			end
			else if (word_end && next_full)
			begin
				next_full <= 1'b0;
				if (bits_left - 13'h0001 > ir_tx_pkg::WORD_BITS)
				begin
					mem_read <= 1'b1;
					mem_address <= mem_address + ir_tx_pkg::WORD_STEP;
					fetch_wait <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// output pin
	// ************************************************************
	logic gated; // carrier passed by a one bit

	assign gated = (state == ir_tx_pkg::ST_SEND) && word_now[bit_index]
		&& carrier; // RL15

	// pin driven only in infra-red mode
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_pin <= 1'b0;
			tx_pin_oe <= 1'b0;
		end
		else
		begin
			tx_pin <= enabled && (gated ^ output_polarity_flip); // RL5 RL6
			tx_pin_oe <= enabled; // RL12
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_idle_level;
		@(posedge clock) disable iff (!reset_n)
		(enabled && !busy && $past(enabled) && $past(!busy))
			|=> (tx_pin == $past(output_polarity_flip));
	endproperty
	a_idle_level: assert property (p_idle_level) // RL6
		else $error("idle pin level wrong");

	property p_pin_release;
		@(posedge clock) disable iff (!reset_n)
		!enabled |=> !tx_pin_oe && !tx_pin;
	endproperty
	a_pin_release: assert property (p_pin_release) // RL12
		else $error("pin driven while disabled");

	property p_start_busy;
		@(posedge clock) disable iff (!reset_n)
		(wr_start && start_valid) |=> busy && mem_read
			&& mem_address == $past(sequence_start_pointer);
	endproperty
	a_start_busy: assert property (p_start_busy) // RL7
		else $error("valid start not taken");

	property p_bad_length;
		@(posedge clock) disable iff (!reset_n)
		(wr_start && !busy && new_count == 13'h0000) |=> !busy
			&& start_rejected;
	endproperty
	a_bad_length: assert property (p_bad_length) // RL8
		else $error("empty sequence started");

	property p_enable_reject;
		@(posedge clock) disable iff (!reset_n)
		(wr_ctrl && reg_write_data[0] && cfg.carrier_period_count == 16'h0000)
			|=> !enabled && enable_rejected;
	endproperty
	a_enable_reject: assert property (p_enable_reject) // RL11
		else $error("bad enable accepted");

	property p_end_irq;
		@(posedge clock) disable iff (!reset_n)
		(end_of_sequence && end_irq_enable && enabled && !wr_ctrl)
			|=> end_irq && !busy;
	endproperty
	a_end_irq: assert property (p_end_irq) // RL10
		else $error("end interrupt missing");

	property p_zero_idle;
		@(posedge clock) disable iff (!reset_n)
		(state == ir_tx_pkg::ST_SEND && !word_now[bit_index] && enabled)
			|=> tx_pin == $past(output_polarity_flip);
	endproperty
	a_zero_idle: assert property (p_zero_idle) // RL15
		else $error("zero bit let carrier through");

	property p_bit_spacing;
		@(posedge clock) disable iff (!reset_n)
		(state == ir_tx_pkg::ST_SEND)
			|-> carrier_index < bit_length_in_carriers;
	endproperty
	a_bit_spacing: assert property (p_bit_spacing) // RL4
		else $error("bit length wrong");
endmodule
`default_nettype wire

//--- design/ir_tx_pkg.sv
`default_nettype none
package ir_tx_pkg;
	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] CARRIER_OFFSET = 8'h04;
	localparam logic [7:0] BIT_LENGTH_OFFSET = 8'h08;
	localparam logic [7:0] POINTER_OFFSET = 8'h0C;
	localparam logic [7:0] START_OFFSET = 8'h10;
	localparam logic [7:0] STATUS_OFFSET = 8'h14;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_FLIP_BIT = 1;
	localparam int CTRL_IRQ_BIT = 2;
	localparam int CTRL_EXP_LSB = 4;
	localparam int CARRIER_PERIOD_LSB = 16;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_ENABLED_BIT = 1;
	localparam int STATUS_DONE_BIT = 2;
	localparam int STATUS_ENREJ_BIT = 3;
	localparam int STATUS_STREJ_BIT = 4;

	// ************************************************************
	// limits and reset values
	// ************************************************************
	localparam logic [4:0] EXPONENT_MAX = 5'h10;
	localparam logic [8:0] BIT_LENGTH_MAX = 9'h100;
	localparam logic [12:0] SEQUENCE_MAX = 13'h1000;
	localparam logic [12:0] WORD_BITS = 13'h0020;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [15:0] CARRIER_RESET = 16'h0000;
	localparam logic [8:0] BIT_LENGTH_RESET = 9'h001;
	localparam logic [31:0] POINTER_RESET = 32'h0000_0000;

	// ************************************************************
	// types
	// ************************************************************
	// transmit sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_SEND = 4'b0100,
		ST_STALL = 4'b1000
	} tx_state_e;

	// carrier shaping settings
	typedef struct packed {
		logic [4:0] clock_divide_exponent;
		logic [15:0] carrier_rise_count;
		logic [15:0] carrier_period_count;
	} carrier_cfg_s;
endpackage
`default_nettype wire

//--- design/carrier_generator.sv
`timescale 1ns/10ps
`default_nettype none
module carrier_generator
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic run,
	input wire ir_tx_pkg::carrier_cfg_s cfg,
	output logic carrier,
	output logic period_end
);
	// ************************************************************
	// prescaler
	// ************************************************************
	logic [16:0] pre_count; // divider position
	logic [16:0] pre_limit; // divide by two to the exponent, minus one
	logic tick; // one timer clock
	logic [15:0] timer_count; // timer clocks since period start

	assign pre_limit = (17'h0_0001 << cfg.clock_divide_exponent) - 17'h0_0001;
	assign tick = run && (pre_count == pre_limit); // RL1

	// divider restarts with every run
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			pre_count <= 17'h0_0000;
		else if (!run || tick)
			pre_count <= 17'h0_0000;
		else
			pre_count <= pre_count + 17'h0_0001;
	end

	// ************************************************************
	// carrier timer
	// ************************************************************
	assign period_end = tick && (timer_count == cfg.carrier_period_count - 16'h0001);

	// wraps at the period count
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			timer_count <= 16'h0000;
		else if (!run || period_end)
			timer_count <= 16'h0000; // RL3
		else if (tick)
			timer_count <= timer_count + 16'h0001;
	end

	// low until the rise count, high until the period ends
	assign carrier = run && (timer_count >= cfg.carrier_rise_count); // RL2

	// ************************************************************
	// checks
	// ************************************************************
	property p_prescale_zero;
		@(posedge clock) disable iff (!reset_n)
		(run && $past(run) && cfg.clock_divide_exponent == 5'h00) |-> tick;
	endproperty
	a_prescale_zero: assert property (p_prescale_zero) // RL1
		else $error("undivided timer clock missing");

	property p_start_low;
		@(posedge clock) disable iff (!reset_n)
		($rose(run) && cfg.carrier_rise_count != 16'h0000) |-> !carrier;
	endproperty
	a_start_low: assert property (p_start_low) // RL2
		else $error("carrier high at timer start");

	property p_wrap_low;
		@(posedge clock) disable iff (!reset_n)
		(period_end && cfg.carrier_rise_count != 16'h0000) |=> !carrier;
	endproperty
	a_wrap_low: assert property (p_wrap_low) // RL3
		else $error("carrier not low after period");
endmodule
`default_nettype wire

//--- verification/ir_ram_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// word store answering one fetch after a set delay
// ************************************************************
module ir_ram_model
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic mem_read,
	input wire logic [31:0] mem_address,
	input wire logic [7:0] latency,
	output logic [31:0] mem_data,
	output logic mem_ready
);
	logic [31:0] words [0:255]; // 32-bit words, byte address over 4
	logic [7:0] wait_count; // cycles left before the answer
	logic pending; // one fetch outstanding
	logic [31:0] held_address; // address of the outstanding fetch
	logic [31:0] last_data; // last word handed out

	// data only stand beside ready; otherwise the inverse of the last
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pending <= 1'b0;
			wait_count <= 8'h00;
			held_address <= 32'h0000_0000;
			last_data <= 32'h0000_0000;
			mem_data <= 32'hFFFF_FFFF;
			mem_ready <= 1'b0;
		end
		else
		begin
			mem_ready <= 1'b0;
			mem_data <= ~last_data;
			if (mem_read)
			begin
				pending <= 1'b1;
				held_address <= mem_address;
				wait_count <= latency;
			end
			else if (pending && wait_count <= 8'h01)
			begin
				mem_ready <= 1'b1;
				mem_data <= words[held_address[9:2]];
				last_data <= words[held_address[9:2]];
				pending <= 1'b0;
			end
			else if (pending)
				wait_count <= wait_count - 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_infrared_carrier_transmitter.sv
`timescale 1ns/10ps
`default_nettype none
module tb_infrared_carrier_transmitter;
	logic clock; // 200 MHz
	logic reset_n;
	logic [7:0] reg_address;
	logic [31:0] reg_write_data;
	logic reg_write;
	logic reg_read;
	logic [31:0] reg_read_data;
	logic mem_read;
	logic [31:0] mem_address;
	logic [31:0] mem_data;
	logic mem_ready;
	logic tx_pin;
	logic tx_pin_oe;
	logic end_irq;
	logic [7:0] latency; // fetch answer delay
	int fail_count;
	int num_checks;
	int fetches = 0; // fetches seen
	logic [31:0] fetch_address = 32'h0000_0000; // last fetch address
	logic [31:0] rd; // last word read

	infrared_carrier_transmitter infrared_carrier_transmitter_i
	(
		.clock(clock), .reset_n(reset_n), .reg_address(reg_address),
		.reg_write_data(reg_write_data), .reg_write(reg_write),
		.reg_read(reg_read), .reg_read_data(reg_read_data),
		.mem_read(mem_read), .mem_address(mem_address),
		.mem_data(mem_data), .mem_ready(mem_ready), .tx_pin(tx_pin),
		.tx_pin_oe(tx_pin_oe), .end_irq(end_irq)
	);
	ir_ram_model ir_ram_model_i
	(
		.clock(clock), .reset_n(reset_n), .mem_read(mem_read),
		.mem_address(mem_address), .latency(latency),
		.mem_data(mem_data), .mem_ready(mem_ready)
	);

	// ************************************************************
	// clock and fetch monitor
	// ************************************************************
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		if (mem_read === 1'b1)
		begin
			fetches <= fetches + 1;
			fetch_address <= mem_address;
		end
	end

	// ************************************************************
	// bus and check helpers
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] expv);
		num_checks++;
		if (got !== expv)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, expv);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		reg_address <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd = reg_read_data;
	endtask
	task automatic cfg(input logic [31:0] c, input logic [31:0] car,
		input logic [8:0] bl);
		wr(ir_tx_pkg::CONTROL_OFFSET, 32'h0000_0000);
		wr(ir_tx_pkg::CARRIER_OFFSET, car);
		wr(ir_tx_pkg::BIT_LENGTH_OFFSET, {23'h00_0000, bl});
		wr(ir_tx_pkg::CONTROL_OFFSET, c);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		rdr(ir_tx_pkg::STATUS_OFFSET);
		while (rd[0] !== 1'b0 && n < 3000)
		begin
			rdr(ir_tx_pkg::STATUS_OFFSET);
			n++;
		end
		if (rd[0] !== 1'b0)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// reset values, unmapped place reads zero
	task automatic t_regs();
		wr(8'h18, 32'hFFFF_FFFF);
		for (int i = 0; i < 7; i++)
		begin
			rdr(8'(i * 4));
			chk(rd, (i == 2) ? 32'h0000_0001 : 32'h0000_0000);
		end
		$display("t_regs done");
	endtask
	// bad settings refused and flagged; limits accepted
	task automatic t_enable();
		logic [31:0] car [0:5];
		logic [8:0] bl [0:5];
		logic [4:0] ex [0:5];
		car = '{32'h0005_0002, 32'h0005_0005, 32'h0000_0000,
			32'h0005_0002, 32'h0005_0002, 32'h0005_0002};
		bl = '{9'h001, 9'h001, 9'h001, 9'h000, 9'h101, 9'h100};
		ex = '{5'h11, 5'h00, 5'h00, 5'h00, 5'h00, 5'h10};
		for (int i = 0; i < 6; i++)
		begin
			cfg({23'h00_0000, ex[i], 4'h1}, car[i], bl[i]);
			rdr(ir_tx_pkg::STATUS_OFFSET);
			chk(rd, (i == 5) ? 32'h0000_0002 : 32'h0000_0008);
			chk({31'h0000_0000, tx_pin_oe}, (i == 5) ? 1 : 0);
			wr(ir_tx_pkg::STATUS_OFFSET, 32'h0000_0008);
		end
		$display("t_enable done");
	endtask
	// carrier shape, bit length, gating, polarity, end flags
	task automatic t_wave();
		logic st [0:119];
		logic [31:0] w;
		logic [4:0] e;
		logic flip;
		logic v;
		int f;
		int s;
		int k;
		int rr;
		int pp;
		w = 32'hFFFF_FFF5;
		ir_ram_model_i.words[64] = w;
		latency <= 8'h02;
		for (int r = 0; r < 2; r++)
		begin
			e = (r == 0) ? 5'h01 : 5'h00;
			flip = (r == 1);
			rr = 2 << e;
			pp = 5 << e;
			cfg({23'h00_0000, e, 1'b0, ~flip, flip, 1'b1}, 32'h0005_0002,
				9'h002);
			wr(ir_tx_pkg::POINTER_OFFSET, 32'h0000_0100);
			wr(ir_tx_pkg::START_OFFSET, 32'h0000_0003);
			for (int j = 0; j < 120; j++)
			begin
				@(posedge clock);
				#1 st[j] = tx_pin;
			end
			f = -1;
			for (int j = 0; j < 120; j++)
				if (f < 0 && st[j] !== flip)
					f = j;
			chk({31'h0000_0000, f >= rr}, 32'h0000_0001);
			s = f - rr;
			for (int j = 0; j < 120; j++)
			begin
				k = j - s;
				v = 1'b0;
				if (k >= 0 && k < 6 * pp)
					v = w[k / (2 * pp)] && (k % pp >= rr);
				chk({31'h0000_0000, st[j]}, {31'h0000_0000, v ^ flip});
			end
			wait_idle();
			chk(rd, 32'h0000_0006);
			chk({31'h0000_0000, end_irq}, {31'h0000_0000, ~flip});
			wr(ir_tx_pkg::STATUS_OFFSET, 32'h0000_0004);
			@(posedge clock);
			chk({31'h0000_0000, end_irq}, 32'h0000_0000);
		end
		$display("t_wave done");
	endtask
	// bad starts refused without fetch; longest run, then abort
	task automatic t_start();
		logic [31:0] len [0:3];
		int n;
		len = '{32'h0000_0000, 32'h0000_1001, 32'h0000_2001, 32'h0000_0001};
		cfg(32'h0000_0001, 32'h0002_0001, 9'h001);
		wr(ir_tx_pkg::POINTER_OFFSET, 32'h0000_0100);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 3)
				wr(ir_tx_pkg::POINTER_OFFSET, 32'h0000_0102);
			n = fetches;
			wr(ir_tx_pkg::START_OFFSET, len[i]);
			rdr(ir_tx_pkg::STATUS_OFFSET);
			chk(rd, 32'h0000_0012);
			chk(fetches, n);
			wr(ir_tx_pkg::STATUS_OFFSET, 32'h0000_0010);
		end
		wr(ir_tx_pkg::POINTER_OFFSET, 32'h0000_0100);
		wr(ir_tx_pkg::START_OFFSET, 32'h0000_1000);
		rdr(ir_tx_pkg::STATUS_OFFSET);
		chk(rd, 32'h0000_0003);
		wr(ir_tx_pkg::CONTROL_OFFSET, 32'h0000_0000);
		rdr(ir_tx_pkg::STATUS_OFFSET);
		chk(rd, 32'h0000_0000);
		chk({30'h0000_0000, tx_pin_oe, tx_pin}, 32'h0000_0000);
		$display("t_start done");
	endtask
	// two words with a slow store: second fetch four bytes on
	task automatic t_multi();
		int n;
		ir_ram_model_i.words[64] = 32'h8000_0001;
		ir_ram_model_i.words[65] = 32'h0000_00FF;
		latency <= 8'h50;
		cfg(32'h0000_0001, 32'h0002_0001, 9'h001);
		wr(ir_tx_pkg::POINTER_OFFSET, 32'h0000_0100);
		n = fetches;
		wr(ir_tx_pkg::START_OFFSET, 32'h0000_0028);
		wait_idle();
		chk(fetches - n, 2);
		chk(fetch_address, 32'h0000_0104);
		chk(rd, 32'h0000_0006);
		$display("t_multi done");
	endtask

	// ************************************************************
	// verdict
	// ************************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		reset_n = 1'b0;
		reg_address = 8'h00;
		reg_write_data = 32'h0000_0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		latency = 8'h02;
		fail_count = 0;
		num_checks = 0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		t_regs();
		t_enable();
		t_wave();
		t_start();
		t_multi();
		report_and_stop();
	end
endmodule
`default_nettype wire
